/* File: usbpg_ctrl.sv */
// Purpose: host pipe global control: interrupt enables, frame counter,
//          pipe enables, pipe resets and pipe device addresses
// Assumes: AHB-Lite slave, zero wait states, single word transfers
// Notes: host events arrive as one-cycle pulses on the same clock
//
// Implementation choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module usbpg_ctrl
    import usbpg_pkg::*;
#(
    parameter int unsigned FRAME_LEN = FRAME_LEN_DEF
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic hready_in,
    input wire logic [31:0] hwdata_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    input wire logic conn_evt_in,
    input wire logic disc_evt_in,
    input wire logic rst_sent_evt_in,
    input wire logic rsm_sent_evt_in,
    input wire logic rsm_rcvd_evt_in,
    input wire logic wakeup_evt_in,
    input wire logic [NUM_PIPES-1:0] pipe_evt_in,
    input wire logic [NUM_DMA-1:0] dma_evt_in,
    input wire logic bus_reset_req_in,
    output logic irq_out,
    output logic sof_out,
    output logic [NUM_PIPES-1:0] pipe_enable_out,
    output logic [NUM_PIPES-1:0] pipe_fifo_rst_out,
    output logic [NUM_PIPES-1:0] pipe_regs_rst_out,
    output logic [NUM_PIPES*DEV_ADDR_W-1:0] pipe_dev_addr_out
);
    // bus slave state
    logic wr_pend_reg;
    logic [ADDR_W-1:0] wr_addr_reg;
    logic [31:0] hrdata_reg;
    logic hreadyout_reg;
    logic hresp_reg;

    // interrupt state
    logic [31:0] irq_en_reg;
    logic [31:0] irq_en_next;
    logic [31:0] irq_stat_reg;
    logic [31:0] irq_stat_next;
    logic [31:0] evt_vec;
    logic irq_reg;

    // frame timer
    logic [FC_W-1:0] fc_count;
    logic [SOF_NUM_W-1:0] sof_number;
    logic sof_pulse;

    // pipe slots
    logic [NUM_PIPES-1:0] pipe_en_w;
    logic [NUM_PIPES-1:0] pipe_rst_w;
    logic [NUM_PIPES-1:0] pipe_regs_w;
    logic [DEV_ADDR_W-1:0] dev_addr_w [NUM_PIPES];

    // address phase decode
    wire addr_take = hsel_in && htrans_in[1] && hready_in;
    wire word_ok = (hsize_in == HSIZE_WORD) && (haddr_in[31:ADDR_W] == '0);
    wire [ADDR_W-1:0] rd_addr = haddr_in[ADDR_W-1:0];
    wire rd_take = addr_take && !hwrite_in;
    wire wr_take = addr_take && hwrite_in && word_ok;

    // data phase write strobes
    wire wr_clr = wr_pend_reg && (wr_addr_reg == OFF_IRQ_CLR);
    wire wr_set = wr_pend_reg && (wr_addr_reg == OFF_EN_SET);
    wire wr_ctrl = wr_pend_reg && (wr_addr_reg == OFF_PIPE_CTRL);
    wire wr_frame = wr_pend_reg && (wr_addr_reg == OFF_FRAME);
    wire wr_lo = wr_pend_reg && (wr_addr_reg == OFF_ADDR_LO);
    wire wr_hi = wr_pend_reg && (wr_addr_reg == OFF_ADDR_HI);
    wire [31:0] set_bits = hwdata_in & IRQ_MASK;
    wire [31:0] clr_bits = wr_clr ? (hwdata_in & IRQ_MASK) : RESET_WORD;

    // read views of the registers
    wire [31:0] pipe_ctrl_rd = {9'h000, pipe_rst_w, 9'h000, pipe_en_w};
    wire [31:0] frame_rd = {8'h00, fc_count[FC_W-1:FC_HIGH_LSB], 2'h0,
                            sof_number, 3'h0};
    wire [31:0] addr_lo_rd = {1'b0, dev_addr_w[3], 1'b0, dev_addr_w[2],
                              1'b0, dev_addr_w[1], 1'b0, dev_addr_w[0]};
    wire [31:0] addr_hi_rd = {8'h00, 1'b0, dev_addr_w[6], 1'b0,
                              dev_addr_w[5], 1'b0, dev_addr_w[4]};
    logic [31:0] rd_mux;

    always_comb begin
        if (!word_ok) begin
            rd_mux = RESET_WORD;
        end else if (rd_addr == OFF_IRQ_STAT) begin
            rd_mux = irq_stat_reg;
        end else if (rd_addr == OFF_IRQ_EN) begin
            rd_mux = irq_en_reg;
        end else if (rd_addr == OFF_PIPE_CTRL) begin
            rd_mux = pipe_ctrl_rd;
        end else if (rd_addr == OFF_FRAME) begin
            rd_mux = frame_rd;
        end else if (rd_addr == OFF_ADDR_LO) begin
            rd_mux = addr_lo_rd;
        end else if (rd_addr == OFF_ADDR_HI) begin
            rd_mux = addr_hi_rd;
        end else begin
            // set and clear registers read as zero, as does a hole
            rd_mux = RESET_WORD;
        end
    end

    // bus slave
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= '0;
            hrdata_reg <= RESET_WORD;
            hreadyout_reg <= 1'b1;
            hresp_reg <= 1'b0;
        end else begin
            wr_pend_reg <= wr_take;
            if (wr_take) begin
                wr_addr_reg <= rd_addr;
            end
            if (rd_take) begin
                hrdata_reg <= rd_mux;
            end
            hreadyout_reg <= 1'b1;
            hresp_reg <= 1'b0;
        end
    end

    // event vector in the status layout
    always_comb begin
        evt_vec = RESET_WORD;
        evt_vec[BIT_CONN] = conn_evt_in;
        evt_vec[BIT_DISC] = disc_evt_in;
        evt_vec[BIT_RST_SENT] = rst_sent_evt_in;
        evt_vec[BIT_RSM_SENT] = rsm_sent_evt_in;
        evt_vec[BIT_RSM_RCVD] = rsm_rcvd_evt_in;
        evt_vec[BIT_SOF] = sof_pulse;
        evt_vec[BIT_WAKEUP] = wakeup_evt_in;
        evt_vec[BIT_PIPE_LSB +: NUM_PIPES] = pipe_evt_in;
        evt_vec[BIT_DMA_LSB +: NUM_DMA] = dma_evt_in;
    end

    // a new event beats a clear in the same cycle
    assign irq_stat_next = (irq_stat_reg & ~clr_bits) | evt_vec;
    assign irq_en_next = wr_set ? (irq_en_reg | set_bits)
                                : irq_en_reg;

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            irq_stat_reg <= RESET_WORD;
            irq_en_reg <= RESET_WORD;
            irq_reg <= 1'b0;
        end else begin
            irq_stat_reg <= irq_stat_next;
            irq_en_reg <= irq_en_next;
            irq_reg <= |(irq_stat_reg & irq_en_reg);
        end
    end

    usbpg_frame_timer #(
        .FRAME_LEN(FRAME_LEN)
    ) u_frame (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .load_in(wr_frame),
        .load_val_in(hwdata_in[SOF_NUM_LSB +: SOF_NUM_W]),
        .count_out(fc_count),
        .sof_num_out(sof_number),
        .sof_out(sof_pulse)
    );

    genvar gi;
    generate
        for (gi = 0; gi < NUM_PIPES; gi++) begin : g_pipe
            localparam int LANE = (gi % ADDR_PER_WORD) * ADDR_LANE_W;
            wire addr_wr = (gi < ADDR_PER_WORD) ? wr_lo : wr_hi;
            usbpg_pipe_slot u_slot (
                .clk_in(clk_in),
                .rst_n_in(rst_n_in),
                .ctrl_wr_in(wr_ctrl),
                .en_bit_in(hwdata_in[gi]),
                .rst_bit_in(hwdata_in[PIPE_RST_LSB + gi]),
                .addr_wr_in(addr_wr),
                .addr_val_in(hwdata_in[LANE +: DEV_ADDR_W]),
                .bus_reset_in(bus_reset_req_in),
                .enable_out(pipe_en_w[gi]),
                .fifo_rst_out(pipe_rst_w[gi]),
                .regs_rst_out(pipe_regs_w[gi]),
                .dev_addr_out(dev_addr_w[gi])
            );
            assign pipe_dev_addr_out[gi*DEV_ADDR_W +: DEV_ADDR_W] =
                dev_addr_w[gi];
        end
    endgenerate

    assign hrdata_out = hrdata_reg;
    assign hreadyout_out = hreadyout_reg;
    assign hresp_out = hresp_reg;
    assign irq_out = irq_reg;
    assign sof_out = sof_pulse;
    assign pipe_enable_out = pipe_en_w;
    assign pipe_fifo_rst_out = pipe_rst_w;
    assign pipe_regs_rst_out = pipe_regs_w;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    // host event enables follow a set write and are never lost
    host_set_a: assert property (
        wr_set |=> ((irq_en_reg & $past(hwdata_in & HOST_EVT_MASK))
                    == $past(hwdata_in & HOST_EVT_MASK)))
        else $error("host event enable not set by write");
    pipe_set_a: assert property (
        wr_set |=> ((irq_en_reg & $past(hwdata_in & PIPE_EVT_MASK))
                    == $past(hwdata_in & PIPE_EVT_MASK)))
        else $error("pipe interrupt enable not set by write");
    dma_set_a: assert property (
        wr_set |=> ((irq_en_reg & $past(hwdata_in & DMA_EVT_MASK))
                    == $past(hwdata_in & DMA_EVT_MASK))
                   && !irq_en_reg[BIT_DMA_LSB - 1])
        else $error("dma enable wrong after set write");
    zero_keeps_a: assert property (
        wr_set |=> ((irq_en_reg & $past(irq_en_reg)) == $past(irq_en_reg)))
        else $error("set write cleared an enable");
    set_reads_zero_a: assert property (
        (rd_take && word_ok && rd_addr == OFF_EN_SET) |=> (hrdata_out == '0))
        else $error("enable set register read nonzero");

    sequence frame_read_s;
        rd_take && word_ok && (rd_addr == OFF_FRAME);
    endsequence
    frame_high_a: assert property (
        frame_read_s |=> (hrdata_out[23:16]
                          == $past(fc_count[FC_W-1:FC_HIGH_LSB])))
        else $error("frame length field differs from counter");
    frame_num_rd_a: assert property (
        frame_read_s |=> (hrdata_out[13:3] == $past(sof_number)))
        else $error("frame number field misplaced");

    sequence masked_quiet_s;
        (irq_stat_reg & irq_en_reg) == '0;
    endsequence
    irq_gate_a: assert property (
        masked_quiet_s ##1 masked_quiet_s |=> !irq_out)
        else $error("interrupt raised with no enabled event");
    irq_raise_a: assert property (
        ((irq_stat_reg & irq_en_reg) != '0) |=> irq_out)
        else $error("enabled event did not raise interrupt");
    sof_flag_a: assert property (
        sof_pulse |=> irq_stat_reg[BIT_SOF])
        else $error("start of frame not flagged");
    addr_lo_wr_a: assert property (
        (wr_lo && !bus_reset_req_in)
        |=> (dev_addr_w[0] == $past(hwdata_in[DEV_ADDR_W-1:0])))
        else $error("pipe zero address not loaded");

    // status is sticky; a clear drops only bits with no new event
    stat_sticky_a: assert property (
        !wr_clr |=> ((irq_stat_reg & $past(irq_stat_reg))
                     == $past(irq_stat_reg)))
        else $error("status bit lost without a clear");
    set_wins_a: assert property (
        (evt_vec != '0) |=> ((irq_stat_reg & $past(evt_vec))
                             == $past(evt_vec)))
        else $error("event lost against a clear");
    stat_clear_a: assert property (
        wr_clr |=> ((irq_stat_reg
                     & $past(hwdata_in & IRQ_MASK & ~evt_vec)) == '0))
        else $error("status bit survived its clear");
    en_hold_a: assert property (
        !wr_set |=> (irq_en_reg == $past(irq_en_reg)))
        else $error("enable changed without a set write");
    en_layout_a: assert property (
        (irq_en_reg & ~IRQ_MASK) == '0)
        else $error("enable set outside the mapped bits");

    stat_read_a: assert property (
        (rd_take && word_ok && rd_addr == OFF_IRQ_STAT)
        |=> (hrdata_out == $past(irq_stat_reg)))
        else $error("status read differs from flags");
    en_read_a: assert property (
        (rd_take && word_ok && rd_addr == OFF_IRQ_EN)
        |=> (hrdata_out == $past(irq_en_reg)))
        else $error("enable read differs from enables");
    ctrl_read_a: assert property (
        (rd_take && word_ok && rd_addr == OFF_PIPE_CTRL)
        |=> (hrdata_out == {9'h000, $past(pipe_rst_w), 9'h000,
                            $past(pipe_en_w)}))
        else $error("pipe control read misplaced");
    addr_hi_rd_a: assert property (
        (rd_take && word_ok && rd_addr == OFF_ADDR_HI)
        |=> (hrdata_out[2*ADDR_LANE_W +: DEV_ADDR_W]
             == $past(dev_addr_w[6])))
        else $error("pipe six address misplaced");

    // a pipe control write lands on every slot at once
    ctrl_write_a: assert property (
        wr_ctrl |=> (pipe_enable_out == $past(hwdata_in[NUM_PIPES-1:0])))
        else $error("pipe enables not loaded");
    fifo_write_a: assert property (
        wr_ctrl |=> (pipe_fifo_rst_out
                     == $past(hwdata_in[PIPE_RST_LSB +: NUM_PIPES])))
        else $error("pipe fifo resets not loaded");
    regs_follow_a: assert property (
        pipe_regs_rst_out == ~pipe_enable_out)
        else $error("pipe register reset does not track disable");
    bus_clear_a: assert property (
        bus_reset_req_in |=> (pipe_dev_addr_out == '0))
        else $error("pipe addresses kept across a bus reset");
    addr_hi_wr_a: assert property (
        (wr_hi && !bus_reset_req_in)
        |=> (dev_addr_w[6] == $past(hwdata_in[2*ADDR_LANE_W +: DEV_ADDR_W])))
        else $error("pipe six address not loaded");
    frame_load_a: assert property (
        wr_frame |=> (sof_number == $past(hwdata_in[SOF_NUM_LSB +: SOF_NUM_W])))
        else $error("frame number not loaded");
    sof_single_a: assert property (
        sof_out |=> !sof_out)
        else $error("start of frame strobe longer than a cycle");
endmodule : usbpg_ctrl
`default_nettype wire

/* File: usbpg_pkg.sv */
// Purpose: shared offsets, field positions and counts of the host pipe
//          global control block
// Assumes: 32-bit word registers on an AHB-Lite slave
// Notes: all offsets are byte addresses
`default_nettype none
package usbpg_pkg;
    localparam int ADDR_W = 12;
    localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 12'h400;
    localparam logic [ADDR_W-1:0] OFF_IRQ_CLR = 12'h404;
    localparam logic [ADDR_W-1:0] OFF_IRQ_EN = 12'h408;
    localparam logic [ADDR_W-1:0] OFF_EN_SET = 12'h418;
    localparam logic [ADDR_W-1:0] OFF_PIPE_CTRL = 12'h41C;
    localparam logic [ADDR_W-1:0] OFF_FRAME = 12'h420;
    localparam logic [ADDR_W-1:0] OFF_ADDR_LO = 12'h424;
    localparam logic [ADDR_W-1:0] OFF_ADDR_HI = 12'h428;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam logic [31:0] RESET_WORD = 32'h00000000;
    localparam int NUM_PIPES = 7;
    localparam int DEV_ADDR_W = 7;
    localparam int ADDR_LANE_W = 8;
    localparam int ADDR_PER_WORD = 4;
    localparam int PIPE_RST_LSB = 16;
    localparam int SOF_NUM_LSB = 3;
    localparam int SOF_NUM_W = 11;
    localparam int FC_W = 14;
    localparam int FC_HIGH_W = 8;
    localparam int FC_HIGH_LSB = FC_W - FC_HIGH_W;
    localparam int FRAME_LEN_DEF = 12000;
    // interrupt status / enable layout
    localparam int BIT_CONN = 0;
    localparam int BIT_DISC = 1;
    localparam int BIT_RST_SENT = 2;
    localparam int BIT_RSM_SENT = 3;
    localparam int BIT_RSM_RCVD = 4;
    localparam int BIT_SOF = 5;
    localparam int BIT_WAKEUP = 6;
    localparam int BIT_PIPE_LSB = 8;
    localparam int BIT_DMA_LSB = 25;
    localparam int NUM_DMA = 6;
    localparam logic [31:0] HOST_EVT_MASK = 32'h0000007F;
    localparam logic [31:0] PIPE_EVT_MASK = 32'h00007F00;
    localparam logic [31:0] DMA_EVT_MASK = 32'h7E000000;
    localparam logic [31:0] IRQ_MASK =
        HOST_EVT_MASK | PIPE_EVT_MASK | DMA_EVT_MASK;
endpackage : usbpg_pkg
`default_nettype wire

/* File: usbpg_frame_timer.sv */
// Purpose: frame counter, start-of-frame strobe and frame number
// Assumes: one count per clock edge
// Notes: a software load of the frame number wins over an increment
`timescale 1ns/1ps
`default_nettype none
module usbpg_frame_timer
    import usbpg_pkg::*;
#(
    parameter int unsigned FRAME_LEN = FRAME_LEN_DEF
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic load_in,
    input wire logic [SOF_NUM_W-1:0] load_val_in,
    output logic [FC_W-1:0] count_out,
    output logic [SOF_NUM_W-1:0] sof_num_out,
    output logic sof_out
);
    localparam logic [FC_W-1:0] LAST = FC_W'(FRAME_LEN - 1);

    logic [FC_W-1:0] cnt_reg;
    logic [FC_W-1:0] cnt_next;
    logic [SOF_NUM_W-1:0] num_reg;
    logic [SOF_NUM_W-1:0] num_next;
    logic sof_reg;
    wire wrap = (cnt_reg == LAST);

    assign cnt_next = wrap ? '0 : cnt_reg + 1'b1;
    assign num_next = load_in ? load_val_in :
                      (wrap ? num_reg + 1'b1 : num_reg);

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            cnt_reg <= '0;
            num_reg <= '0;
            sof_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            num_reg <= num_next;
            sof_reg <= wrap;
        end
    end

    assign count_out = cnt_reg;
    assign sof_num_out = num_reg;
    assign sof_out = sof_reg;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    frame_wrap_a: assert property (
        wrap |=> (cnt_reg == '0) && sof_reg)
        else $error("frame counter did not wrap to zero with a strobe");
    sof_incr_a: assert property (
        (wrap && !load_in) |=> (num_reg == $past(num_reg) + 1'b1))
        else $error("frame number did not advance on start of frame");
endmodule : usbpg_frame_timer
`default_nettype wire

/* File: usbpg_pipe_slot.sv */
// Purpose: enable, fifo reset and device address of one pipe
// Assumes: strobes are one-cycle write pulses on the same clock
// Notes: bus reset wins over a software address write
`timescale 1ns/1ps
`default_nettype none
module usbpg_pipe_slot
    import usbpg_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic ctrl_wr_in,
    input wire logic en_bit_in,
    input wire logic rst_bit_in,
    input wire logic addr_wr_in,
    input wire logic [DEV_ADDR_W-1:0] addr_val_in,
    input wire logic bus_reset_in,
    output logic enable_out,
    output logic fifo_rst_out,
    output logic regs_rst_out,
    output logic [DEV_ADDR_W-1:0] dev_addr_out
);
    logic en_reg;
    logic fifo_rst_reg;
    logic regs_rst_reg;
    logic [DEV_ADDR_W-1:0] addr_reg;

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            en_reg <= 1'b0;
            fifo_rst_reg <= 1'b0;
            regs_rst_reg <= 1'b1;
            addr_reg <= '0;
        end else begin
            if (ctrl_wr_in) begin
                en_reg <= en_bit_in;
                regs_rst_reg <= !en_bit_in;
                fifo_rst_reg <= rst_bit_in;
            end
            if (bus_reset_in) begin
                addr_reg <= '0;
            end else if (addr_wr_in) begin
                addr_reg <= addr_val_in;
            end
        end
    end

    assign enable_out = en_reg;
    assign fifo_rst_out = fifo_rst_reg;
    assign regs_rst_out = regs_rst_reg;
    assign dev_addr_out = addr_reg;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    addr_clear_a: assert property (
        bus_reset_in |=> (dev_addr_out == '0))
        else $error("device address kept across a bus reset");
    disable_clear_a: assert property (
        (ctrl_wr_in && !en_bit_in) |=> (!enable_out && regs_rst_out))
        else $error("disabled pipe not forced inactive");
    fifo_rst_a: assert property (
        (ctrl_wr_in && rst_bit_in && en_bit_in)
        |=> (fifo_rst_out && enable_out && !regs_rst_out))
        else $error("fifo reset disturbed the pipe configuration");
endmodule : usbpg_pipe_slot
`default_nettype wire

/* File: usbpg_far_model.sv */
// Purpose: far side event sources and bus reset requester
// Assumes: driven by the bench through its tasks, same clock as the block
// Notes: events are one-cycle pulses laid out like the status word
`timescale 1ns/1ps
`default_nettype none
module usbpg_far_model
    import usbpg_pkg::*;
(
    input wire logic clk_in,
    output logic [31:0] evt_out,
    output logic bus_reset_out
);
    initial begin
        evt_out = RESET_WORD;
        bus_reset_out = 1'b0;
    end

    task automatic pulse(input logic [31:0] mask);
        @(posedge clk_in);
        evt_out <= mask;
        @(posedge clk_in);
        evt_out <= RESET_WORD;
    endtask : pulse

    // bus reset request held as a level for a number of cycles
    task automatic bus_reset(input int cycles);
        @(posedge clk_in);
        bus_reset_out <= 1'b1;
        repeat (cycles) @(posedge clk_in);
        bus_reset_out <= 1'b0;
    endtask : bus_reset
endmodule : usbpg_far_model
`default_nettype wire

/* File: usbpg_tb.sv */
// Purpose: self-checking bench of the host pipe global control block
// Assumes: single AHB-Lite master, hready looped back from the slave
// Notes: documented frame length kept, so the run spans several frames
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import usbpg_pkg::*;
    localparam int unsigned FLEN = 12000;
    logic clk_in;
    logic rst_n = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h00000000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h00000000;
    wire logic [31:0] hrdata;
    wire logic hready, hresp, irq, sof, bres;
    wire logic [NUM_PIPES-1:0] pen, pfr, prr;
    wire logic [NUM_PIPES*DEV_ADDR_W-1:0] paddr;
    wire logic [31:0] evt;
    int n_fail = 0;
    int n_tests = 0;
    longint cyc = 0;
    longint t0;
    logic [31:0] en;
    logic [31:0] dummy;

    usbpg_ctrl #(.FRAME_LEN(FLEN)) DUT (.clk_in(clk_in), .rst_n_in(rst_n),
        .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
        .hwrite_in(hwrite), .hsize_in(hsize), .hready_in(hready),
        .hwdata_in(hwdata), .hrdata_out(hrdata), .hreadyout_out(hready),
        .hresp_out(hresp), .conn_evt_in(evt[BIT_CONN]),
        .disc_evt_in(evt[BIT_DISC]), .rst_sent_evt_in(evt[BIT_RST_SENT]),
        .rsm_sent_evt_in(evt[BIT_RSM_SENT]),
        .rsm_rcvd_evt_in(evt[BIT_RSM_RCVD]),
        .wakeup_evt_in(evt[BIT_WAKEUP]),
        .pipe_evt_in(evt[BIT_PIPE_LSB +: NUM_PIPES]),
        .dma_evt_in(evt[BIT_DMA_LSB +: NUM_DMA]),
        .bus_reset_req_in(bres), .irq_out(irq), .sof_out(sof),
        .pipe_enable_out(pen), .pipe_fifo_rst_out(pfr),
        .pipe_regs_rst_out(prr), .pipe_dev_addr_out(paddr));

    usbpg_far_model far (.clk_in(clk_in), .evt_out(evt),
        .bus_reset_out(bres));

    initial begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end

    always @(posedge clk_in) cyc <= cyc + 1;

    task automatic check(input string name, input logic [31:0] exp,
                         input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    // one single word transfer; waits on hready at both phases
    task automatic bus(input logic wr, input logic [11:0] off,
                       input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clk_in);
        hsel <= 1'b1;
        haddr <= {20'h00000, off};
        htrans <= 2'h2;
        hwrite <= wr;
        hsize <= HSIZE_WORD;
        do @(posedge clk_in); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk_in); while (hready !== 1'b1);
        rd = hrdata;
        check("hresp okay", 32'h0, 32'(hresp));
    endtask : bus

    task automatic wr(input logic [11:0] off, input logic [31:0] d);
        bus(1'b1, off, d, dummy);
        #1;
    endtask : wr

    task automatic rchk(input string name, input logic [11:0] off,
                        input logic [31:0] exp);
        logic [31:0] rd;
        bus(1'b0, off, 32'h00000000, rd);
        check(name, exp, rd);
        #1;
    endtask : rchk

    task automatic wait_sof;
        int t;
        t = 0;
        do begin
            @(posedge clk_in);
            #1;
            t++;
        end while (sof !== 1'b1 && t < 13000);
        check("sof_out", 32'h1, 32'(sof));
    endtask : wait_sof

    task automatic settle(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask : settle

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_of_test

    initial begin
        // about 36k cycles expected for the whole run
        #5000000;
        n_fail++;
        end_of_test();
    end

    initial begin
        repeat (12) @(posedge clk_in);
        rst_n <= 1'b1;
        #1;
        check("regs_rst reset", 32'h7F, 32'(prr));
        check("dev addr reset", 32'h0, 32'(paddr[31:0]));
        rchk("pipe ctrl reset", OFF_PIPE_CTRL, RESET_WORD);
        rchk("frame reset", OFF_FRAME, RESET_WORD);
        rchk("addr lo reset", OFF_ADDR_LO, RESET_WORD);
        rchk("addr hi reset", OFF_ADDR_HI, RESET_WORD);
        // frame number load, counter top bits, period and wrap
        wait_sof();
        t0 = cyc;
        wr(OFF_FRAME, 32'hFFFFFFFF);
        settle(6420);
        rchk("frame mid", OFF_FRAME, 32'h00643FF8);
        wait_sof();
        check("frame period", FLEN, 32'(cyc - t0));
        rchk("frame wrap", OFF_FRAME, RESET_WORD);
        // events gated by enables
        rchk("enable none", OFF_IRQ_EN, RESET_WORD);
        wr(OFF_EN_SET, RESET_WORD);
        rchk("enable zero", OFF_IRQ_EN, RESET_WORD);
        far.pulse(IRQ_MASK & ~(32'h1 << BIT_SOF));
        settle(3);
        check("irq masked", 32'h0, 32'(irq));
        rchk("status all", OFF_IRQ_STAT, IRQ_MASK);
        en = RESET_WORD;
        for (int b = 0; b < 32; b++) begin
            if (IRQ_MASK[b]) begin
                wr(OFF_IRQ_CLR, 32'hFFFFFFFF);
                wr(OFF_EN_SET, 32'h1 << b);
                en = en | (32'h1 << b);
                rchk("enable set", OFF_IRQ_EN, en);
                rchk("set reads zero", OFF_EN_SET, RESET_WORD);
                check("irq cleared", 32'h0, 32'(irq));
                if (b == BIT_SOF) begin
                    wait_sof();
                end else begin
                    far.pulse(32'h1 << b);
                end
                settle(3);
                check("irq raised", 32'h1, 32'(irq));
            end
        end
        wr(OFF_IRQ_EN, RESET_WORD);
        rchk("enable read only", OFF_IRQ_EN, IRQ_MASK);
        wr(12'h40C, 32'hFFFFFFFF);
        rchk("unmapped", 12'h40C, RESET_WORD);
        // pipe enables and fifo resets
        wr(OFF_PIPE_CTRL, 32'hFFFFFFFF);
        rchk("pipe ctrl", OFF_PIPE_CTRL, 32'h007F007F);
        check("pipe enable", 32'h7F, 32'(pen));
        check("fifo reset", 32'h7F, 32'(pfr));
        check("regs reset on", 32'h0, 32'(prr));
        wr(OFF_PIPE_CTRL, 32'h00000055);
        check("pipe enable part", 32'h55, 32'(pen));
        check("fifo reset done", 32'h0, 32'(pfr));
        check("regs reset off", 32'h0000002A, 32'(prr));
        // pipe device addresses and bus reset
        wr(OFF_ADDR_LO, 32'hFFFFFFFF);
        wr(OFF_ADDR_HI, 32'h12345678);
        rchk("addr lo", OFF_ADDR_LO, 32'h7F7F7F7F);
        rchk("addr hi", OFF_ADDR_HI, 32'h00345678);
        check("addr low pins", 32'h0FFFFFFF, 32'(paddr[27:0]));
        check("addr high pins", {11'h0, 7'h34, 7'h56, 7'h78},
              32'(paddr[48:28]));
        far.bus_reset(2);
        settle(1);
        check("addr cleared", 32'h0, paddr[31:0] | 32'(paddr[48:32]));
        rchk("addr lo cleared", OFF_ADDR_LO, RESET_WORD);
        rchk("addr hi cleared", OFF_ADDR_HI, RESET_WORD);
        // second reset in mid-run
        @(posedge clk_in);
        rst_n <= 1'b0;
        settle(2);
        @(posedge clk_in);
        rst_n <= 1'b1;
        #1;
        check("enable after reset", 32'h0, 32'(pen));
        check("regs_rst after reset", 32'h7F, 32'(prr));
        check("irq after reset", 32'h0, 32'(irq));
        rchk("irq en after reset", OFF_IRQ_EN, RESET_WORD);
        end_of_test();
    end
endmodule : testbench
`default_nettype wire
